// File: crb_pkg.sv
/*
  Constants for the CAN receive buffering block: register map,
  field positions, reset values and receive modes.
  Assumes a 32-bit APB with byte addresses.
*/
package crb_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_IEN   = 8'h08;
  localparam logic [7:0] ADDR_OVF   = 8'h0c;
  localparam logic [7:0] ADDR_MASK0 = 8'h10;
  localparam logic [7:0] ADDR_MASK1 = 8'h14;
  localparam logic [7:0] ADDR_BUF0  = 8'h20;
  localparam logic [7:0] ADDR_BUF1  = 8'h30;
  localparam logic [7:0] BUF_SPAN   = 8'h10;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int BIT_FULL  = 7;
  localparam int BIT_MODEH = 6;
  localparam int BIT_MODEL = 5;
  localparam int BIT_RTR   = 3;
  localparam int BIT_ROLL  = 2;
  localparam int BIT_JUMP  = 1;
  // ----------------------------------------
  // Frame layout in assembly word zero
  // ----------------------------------------
  localparam int BIT_EXT   = 29;
  localparam int BIT_FRTR  = 30;
  localparam int MSG_WORDS = 4;
  localparam int NUM_FILT  = 6;
  localparam int MASK_W    = 29;
  localparam logic [28:0] MASK_RST = 29'h0;
  localparam logic [1:0]  MODE_RST = 2'h0;
  typedef enum logic [1:0] {
    MD_FILT = 2'h0,
    MD_STD  = 2'h1,
    MD_EXT  = 2'h2,
    MD_ALL  = 2'h3
  } crb_mode_t;
endpackage

// File: crb_store_if.sv
/*
  Carrier between the receive control and one receive buffer store.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface crb_store_if;
  logic         load;
  logic [127:0] frame;
  logic [1:0]   rd_idx;
  logic [31:0]  rd_data;
  modport ctl (output load, output frame, output rd_idx, input rd_data);
  modport store (input load, input frame, input rd_idx, output rd_data);
endinterface

// File: crb_rx_store.sv
/*
  One receive buffer: four 32-bit message words loaded as a whole.
  Assumes load is a one-cycle pulse from the receive control.
*/
`timescale 1ns/1ps
module crb_rx_store
  import crb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  crb_store_if.store bus
);
  logic [31:0] word_q [MSG_WORDS];

  genvar w;
  generate
    for (w = 0; w < MSG_WORDS; w++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          word_q[w] <= 32'h0;
        end else if (bus.load) begin
          word_q[w] <= bus.frame[w*32 +: 32];
        end
      end
    end
  endgenerate

  assign bus.rd_data = word_q[bus.rd_idx];
endmodule

// File: crb_rx_ctrl.sv
/*
  CAN receive buffering: assembly buffer, acceptance and rollover
  into two receive buffers, full lockout, overflow, APB registers.
  Assumes filter match and mask comparison happen outside; the
  protocol engine writes assembly words and pulses end of frame.
*/
`timescale 1ns/1ps
module crb_rx_ctrl
  import crb_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Protocol engine
  input  wire logic        mab_we,
  input  wire logic [1:0]  mab_idx,
  input  wire logic [31:0] mab_wdata,
  input  wire logic        frame_ok,
  input  wire logic        frame_err,
  // Acceptance filters
  input  wire logic [5:0]  filt_hit,
  input  wire logic [5:0]  filt_ext,
  output logic [28:0]      mask0,
  output logic [28:0]      mask1,
  // Interrupts
  output logic             rx_irq0,
  output logic             rx_irq1
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] mab_q [MSG_WORDS];
  logic [1:0]  full_q, full_d;
  logic [1:0]  ovf_q, ovf_d;
  logic [1:0]  ien_q;
  logic [1:0]  rtr_q;
  crb_mode_t   mode0_q, mode1_q;
  logic        roll_q;
  logic        hit0_q;
  logic [2:0]  hit1_q;
  logic [28:0] mask0_q, mask1_q;
  logic [31:0] prdata_q;

  crb_store_if sif [2] ();

  // ----------------------------------------
  // Assembly buffer, always writable
  // ----------------------------------------
  genvar w;
  generate
    for (w = 0; w < MSG_WORDS; w++) begin : g_mab
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mab_q[w] <= 32'h0;
        end else if (mab_we && mab_idx == 2'(w)) begin
          mab_q[w] <= mab_wdata;
        end
      end
    end
  endgenerate

  wire frm_ext = mab_q[0][BIT_EXT];
  wire frm_rtr = mab_q[0][BIT_FRTR];

  // ----------------------------------------
  // Filter qualification by receive mode
  // ----------------------------------------
  logic [5:0] use_w;
  genvar f;
  generate
    for (f = 0; f < NUM_FILT; f++) begin : g_filt
      crb_mode_t fmode;
      assign fmode = (f < 2) ? mode0_q : mode1_q;
      assign use_w[f] = filt_hit[f] &
        ((fmode == MD_STD) ? (!filt_ext[f] && !frm_ext) :
         (fmode == MD_EXT) ? (filt_ext[f] && frm_ext) :
         (filt_ext[f] == frm_ext));
    end
  endgenerate

  // ----------------------------------------
  // Acceptance and buffer selection
  // ----------------------------------------
  wire all0  = (mode0_q == MD_ALL);
  wire all1  = (mode1_q == MD_ALL);
  wire take0 = (frame_ok && (all0 || use_w[0] || use_w[1]))
            || (frame_err && all0);
  wire take1 = (frame_ok && (all1 || (|use_w[5:2])))
            || (frame_err && all1);
  wire roll  = frame_ok && take0 && full_q[0] && roll_q;
  wire ld0   = take0 && !full_q[0];
  wire to1   = roll || (take1 && !ld0);
  wire ld1   = to1 && !full_q[1];
  wire ovf0  = take0 && full_q[0] && !to1;
  wire ovf1  = to1 && full_q[1];
  wire h0    = use_w[1] && !use_w[0];
  wire [2:0] h1 = roll ? {2'h0, h0} :
                  use_w[2] ? 3'h2 :
                  use_w[3] ? 3'h3 :
                  use_w[4] ? 3'h4 :
                  use_w[5] ? 3'h5 : 3'h0;

  // ----------------------------------------
  // Receive buffer stores
  // ----------------------------------------
  wire [127:0] mab_flat = {mab_q[3], mab_q[2], mab_q[1], mab_q[0]};
  assign sif[0].load   = ld0;
  assign sif[1].load   = ld1;
  assign sif[0].frame  = mab_flat;
  assign sif[1].frame  = mab_flat;
  assign sif[0].rd_idx = paddr[3:2];
  assign sif[1].rd_idx = paddr[3:2];

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_buf
      crb_rx_store u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (sif[b])
      );
    end
  endgenerate

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire wr_en   = psel && penable && pwrite;
  wire rd_set  = psel && !penable && !pwrite;
  wire a_ctrl0 = (paddr == ADDR_CTRL0);
  wire a_ctrl1 = (paddr == ADDR_CTRL1);
  wire a_ien   = (paddr == ADDR_IEN);
  wire a_ovf   = (paddr == ADDR_OVF);
  wire a_mask0 = (paddr == ADDR_MASK0);
  wire a_mask1 = (paddr == ADDR_MASK1);
  wire a_buf0  = (paddr >= ADDR_BUF0) && (paddr < ADDR_BUF0 + BUF_SPAN);
  wire a_buf1  = (paddr >= ADDR_BUF1) && (paddr < ADDR_BUF1 + BUF_SPAN);
  wire aligned = (paddr[1:0] == 2'h0);
  wire mapped  = aligned && (a_ctrl0 || a_ctrl1 || a_ien || a_ovf ||
                 a_mask0 || a_mask1 || a_buf0 || a_buf1);
  wire w_ctrl0 = wr_en && mapped && a_ctrl0;
  wire w_ctrl1 = wr_en && mapped && a_ctrl1;
  wire clr0    = w_ctrl0 && !pwdata[BIT_FULL];
  wire clr1    = w_ctrl1 && !pwdata[BIT_FULL];
  // Write strobes for the remaining registers
  wire w_ien   = wr_en && mapped && a_ien;
  wire w_ovf   = wr_en && mapped && a_ovf;
  wire w_mask0 = wr_en && mapped && a_mask0;
  wire w_mask1 = wr_en && mapped && a_mask1;

  wire [31:0] ctrl0_v = {24'h0, full_q[0], mode0_q, 1'b0, rtr_q[0],
                         roll_q, roll_q, hit0_q};
  wire [31:0] ctrl1_v = {24'h0, full_q[1], mode1_q, 1'b0, rtr_q[1],
                         hit1_q};
  wire [31:0] rd_mux =
    !mapped ? 32'h0 :
    a_ctrl0 ? ctrl0_v :
    a_ctrl1 ? ctrl1_v :
    a_ien   ? {30'h0, ien_q} :
    a_ovf   ? {30'h0, ovf_q} :
    a_mask0 ? {3'h0, mask0_q} :
    a_mask1 ? {3'h0, mask1_q} :
    a_buf0  ? sif[0].rd_data : sif[1].rd_data;

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign mask0   = mask0_q;
  assign mask1   = mask1_q;
  assign rx_irq0 = full_q[0] && ien_q[0];
  assign rx_irq1 = full_q[1] && ien_q[1];

  // ----------------------------------------
  // Flags: hardware set wins over software clear
  // ----------------------------------------
  assign full_d = {ld1 | (full_q[1] & !clr1),
                   ld0 | (full_q[0] & !clr0)};
  wire [1:0] ovf_clr = w_ovf ? pwdata[1:0] : 2'h0;
  assign ovf_d = {ovf1, ovf0} | (ovf_q & ~ovf_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 2'h0;
      ovf_q  <= 2'h0;
    end else begin
      full_q <= full_d;
      ovf_q  <= ovf_d;
    end
  end

  // Status captured with each load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtr_q  <= 2'h0;
      hit0_q <= 1'b0;
      hit1_q <= 3'h0;
    end else begin
      if (ld0) begin
        rtr_q[0] <= frm_rtr;
        hit0_q   <= h0;
      end
      if (ld1) begin
        rtr_q[1] <= frm_rtr;
        hit1_q   <= h1;
      end
    end
  end

  // Receive mode per buffer, rollover enable for buffer zero only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode0_q <= crb_mode_t'(MODE_RST);
      mode1_q <= crb_mode_t'(MODE_RST);
      roll_q  <= 1'b0;
    end else begin
      if (w_ctrl0) begin
        mode0_q <= crb_mode_t'(pwdata[BIT_MODEH:BIT_MODEL]);
        roll_q  <= pwdata[BIT_ROLL];
      end
      if (w_ctrl1) begin
        mode1_q <= crb_mode_t'(pwdata[BIT_MODEH:BIT_MODEL]);
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= 2'h0;
    end else if (w_ien) begin
      ien_q <= pwdata[1:0];
    end
  end

  // Acceptance masks, one per buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask0_q <= MASK_RST;
      mask1_q <= MASK_RST;
    end else begin
      if (w_mask0) begin
        mask0_q <= pwdata[MASK_W-1:0];
      end
      if (w_mask1) begin
        mask1_q <= pwdata[MASK_W-1:0];
      end
    end
  end

  // Read data taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (rd_set) begin
      prdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  full_lock_a: assert property (full_q[0] |-> !sif[0].load)
    else $error("load into full buffer zero");
  full_set_a: assert property (ld1 |=> full_q[1])
    else $error("full flag not set after load");
  irq_out_a: assert property (full_q[1] && ien_q[1] |-> rx_irq1)
    else $error("interrupt missing for full buffer");
  roll_move_a: assert property (frame_ok && take0 && full_q[0] && roll_q
    && !full_q[1] |-> ld1 && !ovf0 ##1 !ovf_q[0] || $past(ovf_q[0]))
    else $error("rollover did not move the frame");
  prio_zero_a: assert property (ld0 |-> !ld1)
    else $error("frame loaded into both buffers");
  filt_gate_a: assert property (ld0 && !all0 |-> use_w[0] || use_w[1])
    else $error("load without filter match");
  err_load_a: assert property (frame_err && all0 && !full_q[0]
    |=> full_q[0])
    else $error("errored frame not loaded in receive-all");
  std_only_a: assert property (ld0 && mode0_q == MD_STD |-> !frm_ext)
    else $error("extended frame taken in standard mode");
  ovf_flag_a: assert property (ovf0 |=> ovf_q[0][*2] or ##1 $past(ovf_clr[0]))
    else $error("overflow not recorded");
  hit_num_a: assert property (ld0 |=> hit0_q == $past(h0))
    else $error("filter hit number wrong");
  jump_copy_a: assert property (psel && penable && !pwrite && a_ctrl0
    |-> prdata[BIT_JUMP] == roll_q)
    else $error("jump copy differs from rollover enable");

  // Lockout, capture and routing
  full_hold0_a: assert property (full_q[0] && !clr0 |=> full_q[0])
    else $error("buffer zero full flag dropped by hardware");
  full_hold1_a: assert property (full_q[1] && !clr1 |=> full_q[1])
    else $error("buffer one full flag dropped by hardware");
  mab_word_a: assert property (mab_we && mab_idx == 2'h0 |=> mab_q[0] == $past(mab_wdata))
    else $error("assembly word not captured");
  ext_only_a: assert property (ld0 && mode0_q == MD_EXT |-> frm_ext)
    else $error("standard frame taken in extended mode");
  std_one_a: assert property (ld1 && !roll && mode1_q == MD_STD |-> !frm_ext)
    else $error("extended frame taken by buffer one in standard mode");
  all_mode_a: assert property (frame_ok && all0 && !full_q[0] |=> full_q[0])
    else $error("frame not taken in receive-all mode");
  err_skip_a: assert property (frame_err && !frame_ok && !all0 |-> !ld0)
    else $error("errored frame loaded outside receive-all");
  filt_one_a: assert property (ld1 && !all1 && !roll |-> |use_w[5:2])
    else $error("buffer one load without its own filter");
  no_roll_a: assert property (frame_ok && take0 && full_q[0] && !roll_q && !take1
    |-> ovf0 && !ld1)
    else $error("overflow not raised without rollover");
  ovf_one_a: assert property (ovf1 |=> ovf_q[1])
    else $error("buffer one overflow not recorded");
  ovf_sticky_a: assert property (ovf_q[1] && !ovf_clr[1] |=> ovf_q[1])
    else $error("overflow flag dropped without a clear");
  roll_hit_a: assert property (roll && ld1 |=> hit1_q[2:1] == 2'h0)
    else $error("rollover did not report a buffer zero filter");
  hit_one_a: assert property (ld1 |=> hit1_q == $past(h1))
    else $error("buffer one filter number wrong");
  rtr_copy_a: assert property (ld0 |=> rtr_q[0] == $past(frm_rtr))
    else $error("remote request bit not captured");
  irq_set_a: assert property (ld0 && ien_q[0] && !w_ien |=> rx_irq0)
    else $error("interrupt missing after load");
  ign_wr_a: assert property (wr_en && !mapped |=> $stable(mask0_q) && $stable(ien_q))
    else $error("unmapped write changed a register");
  mask_out_a: assert property (w_mask1 |=> mask1 == $past(pwdata[MASK_W-1:0]))
    else $error("mask one not written");

  // Main scenarios
  load_zero_c: cover property (ld0 ##[1:20] clr0);
  rollover_c: cover property (roll && ld1);
  overflow_c: cover property (ovf1);
  err_load_c: cover property (frame_err && ld0);
  ext_mode_c: cover property (ld0 && mode0_q == MD_EXT);
endmodule

// File: crb_engine_model.sv
/*
  Behavioural protocol engine and filter bank facing the receive control.
  Assumes the bench calls send and that pclk is the controller clock.
*/
`timescale 1ns/1ps
module crb_engine_model (
  // Clock
  input  wire logic   pclk,
  // Assembly buffer writes
  output logic        mab_we,
  output logic [1:0]  mab_idx,
  output logic [31:0] mab_wdata,
  // Frame end and filter results
  output logic        frame_ok,
  output logic        frame_err,
  output logic [5:0]  filt_hit,
  output logic [5:0]  filt_ext
);
  initial begin
    mab_we = 1'b0;
    mab_idx = 2'h0;
    mab_wdata = 32'h0;
    frame_ok = 1'b0;
    frame_err = 1'b0;
    filt_hit = 6'h0;
    filt_ext = 6'h0;
  end
  // ----------------------------------------
  // One frame: four words, then end pulse
  // ----------------------------------------
  task automatic send(input logic [127:0] f, input logic [5:0] h, input logic [5:0] x, input logic e);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      mab_we <= 1'b1;
      mab_idx <= 2'(i);
      mab_wdata <= f[32 * i +: 32];
    end
    @(posedge pclk);
    mab_we <= 1'b0;
    mab_idx <= ~mab_idx;
    // Released lines must not keep their last value
    mab_wdata <= ~mab_wdata;
    filt_ext <= x;
    filt_hit <= h;
    frame_ok <= ~e;
    frame_err <= e;
    @(posedge pclk);
    frame_ok <= 1'b0;
    frame_err <= 1'b0;
    filt_hit <= ~h;
  endtask
endmodule

// File: testbench.sv
/*
  Self-checking bench for the receive buffering block.
  Assumes the engine model drives the frame side and APB reaches registers.
*/
`timescale 1ns/1ps
module testbench;
  import crb_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        mab_we, frame_ok, frame_err, rx_irq0, rx_irq1;
  logic [1:0]  mab_idx;
  logic [5:0]  filt_hit, filt_ext;
  logic [7:0]  paddr;
  logic [28:0] mask0, mask1;
  logic [31:0] pwdata, prdata, mab_wdata, rd;
  int          bad_count, checks_done;
  localparam logic [127:0] FS = {32'hc3c3c3c3, 32'hb2b2b2b2, 32'ha1a1a1a1, 32'h000001a5};
  localparam logic [127:0] FX = {32'h0f0f0f0f, 32'h12345678, 32'h9abcdef0, 32'h20012345};
  localparam logic [127:0] FR = {32'h55aa55aa, 32'h00ff00ff, 32'h0000000f, 32'h40000123};

  crb_rx_ctrl crb_rx_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mab_we, .mab_idx, .mab_wdata, .frame_ok, .frame_err, .filt_hit, .filt_ext, .mask0, .mask1,
    .rx_irq0, .rx_irq1);
  crb_engine_model crb_engine_model_i (.pclk, .mab_we, .mab_idx, .mab_wdata, .frame_ok, .frame_err,
    .filt_hit, .filt_ext);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_sim();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic bchk(input logic [7:0] b, input logic [127:0] f);
    for (int i = 0; i < MSG_WORDS; i++) begin
      rchk("buffer word", b + 8'(4 * i), f[32 * i +: 32]);
    end
  endtask
  // Clears both buffers, sets control zero, sends one frame, checks control zero
  task automatic tryf(input logic [7:0] c, input logic [127:0] f, input logic [5:0] h, input logic [5:0] x,
    input logic e, input logic [7:0] ex);
    apb(1'b1, ADDR_CTRL0, {24'h0, c});
    apb(1'b1, ADDR_CTRL1, {24'h0, c & 8'h60});
    apb(1'b1, ADDR_OVF, 32'h3);
    crb_engine_model_i.send(f, h, x, e);
    rchk("control zero", ADDR_CTRL0, {24'h0, ex});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk("control zero", ADDR_CTRL0, 32'h0);
    rchk("control one", ADDR_CTRL1, 32'h0);
    rchk("overflow", ADDR_OVF, 32'h0);
    rchk("mask zero", ADDR_MASK0, 32'h0);
    chk("irq zero", {31'h0, rx_irq0}, 32'h0);
    apb(1'b1, ADDR_IEN, 32'h3);
    rchk("irq enable", ADDR_IEN, 32'h3);
  endtask
  task automatic t_regs();
    apb(1'b1, ADDR_MASK0, 32'hffffffff);
    rchk("mask zero", ADDR_MASK0, 32'h1fffffff);
    chk("mask zero port", {3'h0, mask0}, 32'h1fffffff);
    apb(1'b1, ADDR_MASK1, 32'h0abcdef0);
    rchk("mask one", ADDR_MASK1, 32'h0abcdef0);
    chk("mask one port", {3'h0, mask1}, 32'h0abcdef0);
    rchk("unmapped", 8'h18, 32'h0);
    chk("unmapped error", {31'h0, se}, 32'h1);
    apb(1'b1, ADDR_CTRL0, 32'h0a);
    rchk("read only bits", ADDR_CTRL0, 32'h0);
  endtask
  task automatic t_accept();
    tryf(8'h00, FS, 6'h00, 6'h00, 1'b0, 8'h00);
    tryf(8'h00, FS, 6'h01, 6'h01, 1'b0, 8'h00);
    tryf(8'h00, FS, 6'h01, 6'h00, 1'b1, 8'h00);
    tryf(8'h00, FS, 6'h06, 6'h00, 1'b0, 8'h81);
    rchk("control one", ADDR_CTRL1, 32'h0);
    chk("irq zero", {31'h0, rx_irq0}, 32'h1);
    bchk(ADDR_BUF0, FS);
    crb_engine_model_i.send(FX, 6'h01, 6'h3f, 1'b0);
    rchk("overflow", ADDR_OVF, 32'h1);
    rchk("locked word", ADDR_BUF0, FS[31:0]);
    crb_engine_model_i.send(FX, 6'h11, 6'h3f, 1'b0);
    rchk("control one", ADDR_CTRL1, 32'h84);
    chk("irq one", {31'h0, rx_irq1}, 32'h1);
    bchk(ADDR_BUF1, FX);
    crb_engine_model_i.send(FR, 6'h11, 6'h00, 1'b0);
    rchk("overflow", ADDR_OVF, 32'h3);
    rchk("locked word", ADDR_BUF1, FX[31:0]);
    apb(1'b1, ADDR_CTRL0, 32'h0);
    rchk("control zero", ADDR_CTRL0, 32'h01);
    chk("irq zero", {31'h0, rx_irq0}, 32'h0);
  endtask
  task automatic t_roll();
    tryf(8'h04, FS, 6'h01, 6'h00, 1'b0, 8'h86);
    crb_engine_model_i.send(FX, 6'h01, 6'h3f, 1'b0);
    rchk("control one", ADDR_CTRL1, 32'h80);
    rchk("overflow", ADDR_OVF, 32'h0);
    bchk(ADDR_BUF1, FX);
  endtask
  task automatic t_modes();
    tryf(8'h20, FX, 6'h01, 6'h01, 1'b0, 8'h20);
    tryf(8'h20, FS, 6'h01, 6'h01, 1'b0, 8'h20);
    tryf(8'h20, FS, 6'h01, 6'h00, 1'b0, 8'ha0);
    tryf(8'h40, FS, 6'h01, 6'h00, 1'b0, 8'h40);
    tryf(8'h40, FX, 6'h01, 6'h00, 1'b0, 8'h40);
    tryf(8'h40, FX, 6'h01, 6'h01, 1'b0, 8'hc0);
    // Receive-everything mode: an errored frame and an unmatched frame are both loaded and checked
    tryf(8'h60, FR, 6'h00, 6'h00, 1'b1, 8'he8);
    bchk(ADDR_BUF0, FR);
    tryf(8'h60, FX, 6'h00, 6'h00, 1'b0, 8'he0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_accept();
    t_roll();
    t_modes();
    end_sim();
  end
endmodule
